// [rtl/csie_defines.vh]
// Constants for the card socket interrupt event block
//Functional notes
//- Functional requests ignored for memory cards
//- Detect line transitions flag socket bits 2,1
//- Memory card battery transitions flag bits 1,0
//- Memory card ready transitions flag bit 2
//- I/O card status change flags bit 0
//- CardBus status change flags socket bit 0
//- Functional requests unmasked, reported at 0x91 bit0
//- Power-up complete flags bit 3
//- Each maskable source has own mask
//- Every source has a status flag
//- Change and functional interrupts routed separately
//- Legacy flags clear on read or write-one
//- Socket event flags clear only by write-one
//- Parallel pins driven only in parallel mode
//- Pin code per function and mode
`ifndef CSIE_DEFINES_VH
`define CSIE_DEFINES_VH

// ----------------------------------------
// Register byte addresses (index times four)
// ----------------------------------------
`define CSIE_IDX_CHG_FLAGS 12'h004
`define CSIE_IDX_CHG_MASKS 12'h005
`define CSIE_IDX_GLOBAL_CTL 12'h01e
`define CSIE_IDX_CARD_CTL 12'h091
`define CSIE_IDX_MODE_CTL 12'h092
`define CSIE_ADDR_CHG_FLAGS 12'h010
`define CSIE_ADDR_CHG_MASKS 12'h014
`define CSIE_ADDR_GLOBAL_CTL 12'h078
`define CSIE_ADDR_CARD_CTL 12'h244
`define CSIE_ADDR_MODE_CTL 12'h248
`define CSIE_ADDR_SOCK_EVENT 12'h400
`define CSIE_ADDR_SOCK_MASK 12'h404
`define CSIE_ADDR_ROUTE 12'h408
`define CSIE_ADDR_PIN_CODE 12'h40c

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define CSIE_BIT_BATT0 0
`define CSIE_BIT_BATT1 1
`define CSIE_BIT_READY 2
`define CSIE_BIT_CARD_STS 0
`define CSIE_BIT_PWR 3
`define CSIE_BIT_CB_STS 0
`define CSIE_BIT_CD_LO 1
`define CSIE_BIT_CD_HI 2
`define CSIE_BIT_FUNC 0
`define CSIE_BIT_W1C_SEL 2
`define CSIE_MODE_LSB 1
`define CSIE_MODE_MSB 2
`define CSIE_MODE_PARALLEL 2'h0
`define CSIE_MODE_RESERVED 2'h1
`define CSIE_MODE_SER_PAR 2'h2
`define CSIE_MODE_SERIAL 2'h3
`define CSIE_PIN_INTA 8'h01
`define CSIE_PIN_INTB 8'h02
`define CSIE_CARD_MEM 2'h0
`define CSIE_CARD_IO 2'h1
`define CSIE_CARD_CB 2'h2
`define CSIE_CARD_NONE 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSIE_RST_MODE 8'h06
`define CSIE_RST_ROUTE 8'h10
`define CSIE_RST_BYTE 8'h00

`endif

// [rtl/csie_sync.v]
// Two-flop synchroniser with edge detection for card lines
`timescale 1ns/10ps
module csie_sync (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Lines
    input wire [7:0] din,
    output wire [7:0] level,
    output wire [7:0] toggled
);
    reg [7:0] meta_reg;
    reg [7:0] sync_reg;
    reg [7:0] prev_reg;
    reg [1:0] fill_reg;

    // Two flops, then a history flop for transition detect
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 8'h00;
            sync_reg <= 8'h00;
            prev_reg <= 8'h00;
            fill_reg <= 2'h0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
            if (fill_reg != 2'h3) begin
                fill_reg <= fill_reg + 2'h1;
            end
        end
    end

    // A line that idles high would look like a transition while the flops fill
    assign level = sync_reg;
    assign toggled = (sync_reg ^ prev_reg) & {8{fill_reg == 2'h3}};
endmodule // csie_sync

// [rtl/csie_top.v]
// Socket interrupt event logic with APB register slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "csie_defines.vh"
module csie_top (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Card side lines
    input wire [1:0] card_type,
    input wire battery_detect_one,
    input wire battery_detect_two,
    input wire card_ready_line,
    input wire card_detect_one,
    input wire card_detect_two,
    input wire card_irq_request,
    input wire power_up_done,
    // Interrupt outputs
    output reg change_irq,
    output reg func_irq,
    output reg [2:0] multifunction_pin
);
    // ----------------------------------------
    // Line synchronisation
    // ----------------------------------------
    wire [7:0] lvl;
    wire [7:0] tog;

    // Lines: 0,1 battery/status, 2 ready, 3,4 detect, 5 request, 6 power done
    csie_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({1'b0, power_up_done, card_irq_request, card_detect_two,
              card_detect_one, card_ready_line, battery_detect_two,
              battery_detect_one}),
        .level(lvl),
        .toggled(tog)
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [3:0] chg_flags_reg;
    reg [3:0] chg_flags_next;
    reg [3:0] chg_masks_reg;
    reg [7:0] global_ctl_reg;
    reg func_flag_reg;
    reg [7:0] mode_ctl_reg;
    reg [3:0] sock_event_reg;
    reg [3:0] sock_event_next;
    reg [3:0] sock_mask_reg;
    reg [7:0] route_reg;
    reg [31:0] prdata_reg;

    wire is_mem = (card_type == `CSIE_CARD_MEM);
    wire is_io = (card_type == `CSIE_CARD_IO);
    wire is_cb = (card_type == `CSIE_CARD_CB);
    wire is_16 = is_mem | is_io;
    wire [1:0] mode = mode_ctl_reg[`CSIE_MODE_MSB:`CSIE_MODE_LSB];

    // Access decode
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;

    // Address match helper
    function hit;
        input [11:0] a;
        input [11:0] ref_addr;
        begin
            hit = (a == ref_addr);
        end
    endfunction

    wire mapped = hit(paddr, `CSIE_ADDR_CHG_FLAGS) | hit(paddr, `CSIE_ADDR_CHG_MASKS) |
                  hit(paddr, `CSIE_ADDR_GLOBAL_CTL) | hit(paddr, `CSIE_ADDR_CARD_CTL) |
                  hit(paddr, `CSIE_ADDR_MODE_CTL) | hit(paddr, `CSIE_ADDR_SOCK_EVENT) |
                  hit(paddr, `CSIE_ADDR_SOCK_MASK) | hit(paddr, `CSIE_ADDR_ROUTE) |
                  hit(paddr, `CSIE_ADDR_PIN_CODE);

    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_reg;

    // ----------------------------------------
    // Event sources
    // ----------------------------------------
    wire pwr_evt = tog[6] & lvl[6];
    wire cd_evt = tog[3] | tog[4];
    reg [3:0] leg_set;
    reg [3:0] sock_set;

    // Card-type steering of events into flag sets
    always @* begin
        leg_set = 4'h0;
        sock_set = 4'h0;
        if (is_mem) begin
            leg_set[`CSIE_BIT_BATT0] = tog[0];
            leg_set[`CSIE_BIT_BATT1] = tog[1];
            leg_set[`CSIE_BIT_READY] = tog[2];
        end
        if (is_io) begin
            leg_set[`CSIE_BIT_CARD_STS] = tog[0] & lvl[0];
        end
        if (is_16) begin
            leg_set[`CSIE_BIT_PWR] = pwr_evt;
        end
        if (is_cb) begin
            sock_set[`CSIE_BIT_CB_STS] = tog[0] & lvl[0];
            sock_set[`CSIE_BIT_PWR] = pwr_evt;
        end
        sock_set[`CSIE_BIT_CD_LO] = cd_evt;
        sock_set[`CSIE_BIT_CD_HI] = cd_evt;
    end

    // Functional request valid only for I/O and CardBus cards
    wire func_req = lvl[5] & (is_io | is_cb);

    // ----------------------------------------
    // Flag next-state: set wins over clear
    // ----------------------------------------
    wire w1c_mode = global_ctl_reg[`CSIE_BIT_W1C_SEL];
    always @* begin
        chg_flags_next = chg_flags_reg;
        if (hit(paddr, `CSIE_ADDR_CHG_FLAGS)) begin
            if (w1c_mode && wr) begin
                chg_flags_next = chg_flags_reg & ~pwdata[3:0];
            end else if (!w1c_mode && rd) begin
                // Clear only the bits captured for this read, so a late event survives
                chg_flags_next = chg_flags_reg & ~prdata_reg[3:0];
            end
        end
        chg_flags_next = chg_flags_next | leg_set;
        sock_event_next = sock_event_reg;
        if (wr && hit(paddr, `CSIE_ADDR_SOCK_EVENT)) begin
            sock_event_next = sock_event_reg & ~pwdata[3:0];
        end
        sock_event_next = sock_event_next | sock_set;
    end

    // ----------------------------------------
    // Register writes and flag updates
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_flags_reg <= 4'h0;
            chg_masks_reg <= 4'h0;
            global_ctl_reg <= `CSIE_RST_BYTE;
            func_flag_reg <= 1'b0;
            mode_ctl_reg <= `CSIE_RST_MODE;
            sock_event_reg <= 4'h0;
            sock_mask_reg <= 4'h0;
            route_reg <= `CSIE_RST_ROUTE;
        end else begin
            chg_flags_reg <= chg_flags_next;
            sock_event_reg <= sock_event_next;
            func_flag_reg <= func_req;
            if (wr) begin
                if (hit(paddr, `CSIE_ADDR_CHG_MASKS)) begin
                    chg_masks_reg <= pwdata[3:0];
                end
                if (hit(paddr, `CSIE_ADDR_GLOBAL_CTL)) begin
                    global_ctl_reg <= pwdata[7:0];
                end
                if (hit(paddr, `CSIE_ADDR_MODE_CTL)) begin
                    mode_ctl_reg <= pwdata[7:0];
                end
                if (hit(paddr, `CSIE_ADDR_SOCK_MASK)) begin
                    sock_mask_reg <= pwdata[3:0];
                end
                if (hit(paddr, `CSIE_ADDR_ROUTE)) begin
                    route_reg <= pwdata[7:0];
                end
            end
        end
    end

    // ----------------------------------------
    // Pin code per function
    // ----------------------------------------
    wire [7:0] pin_f0 = `CSIE_PIN_INTA;
    wire [7:0] pin_f1 = (mode == `CSIE_MODE_SER_PAR) ? `CSIE_PIN_INTA : `CSIE_PIN_INTB;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `CSIE_ADDR_CHG_FLAGS: prdata_reg <= {28'h0, chg_flags_reg};
                `CSIE_ADDR_CHG_MASKS: prdata_reg <= {28'h0, chg_masks_reg};
                `CSIE_ADDR_GLOBAL_CTL: prdata_reg <= {24'h0, global_ctl_reg};
                `CSIE_ADDR_CARD_CTL: prdata_reg <= {31'h0, func_flag_reg};
                `CSIE_ADDR_MODE_CTL: prdata_reg <= {24'h0, mode_ctl_reg};
                `CSIE_ADDR_SOCK_EVENT: prdata_reg <= {28'h0, sock_event_reg};
                `CSIE_ADDR_SOCK_MASK: prdata_reg <= {28'h0, sock_mask_reg};
                `CSIE_ADDR_ROUTE: prdata_reg <= {24'h0, route_reg};
                `CSIE_ADDR_PIN_CODE: prdata_reg <= {16'h0, pin_f1, pin_f0};
                default: prdata_reg <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // Interrupt generation and routing
    // ----------------------------------------
    wire change_any = (|(chg_flags_reg & chg_masks_reg) & is_16) |
        (|(sock_event_reg & sock_mask_reg));
    wire [2:0] pin_change = route_reg[2:0];
    wire [2:0] pin_func = route_reg[6:4];
    reg [2:0] mf_next;

    // Parallel pins driven only in pure parallel mode
    always @* begin
        mf_next = 3'h0;
        if (mode == `CSIE_MODE_PARALLEL) begin
            if (change_any && pin_change < 3'h3) begin
                mf_next[pin_change[1:0]] = 1'b1;
            end
            if (func_flag_reg && pin_func < 3'h3) begin
                mf_next[pin_func[1:0]] = 1'b1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_irq <= 1'b0;
            func_irq <= 1'b0;
            multifunction_pin <= 3'h0;
        end else begin
            change_irq <= change_any;
            func_irq <= func_flag_reg;
            multifunction_pin <= mf_next;
        end
    end
endmodule // csie_top

// [sim/csie_top_sva.sv]
// Concurrent checks on the socket interrupt block ports
`timescale 1ns/10ps
`include "csie_defines.vh"
module csie_top_sva (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Card and interrupt lines
    input wire [1:0] card_type,
    input wire card_irq_request,
    input wire change_irq,
    input wire func_irq,
    input wire [2:0] multifunction_pin
);
    logic [1:0] mode_reg;
    logic [3:0] lmask_reg;
    logic [3:0] smask_reg;
    wire acc = psel && penable;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow copies of mode and mask fields written by software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= 2'h3;
            lmask_reg <= 4'h0;
            smask_reg <= 4'h0;
        end else if (acc && pwrite) begin
            if (paddr == `CSIE_ADDR_MODE_CTL) mode_reg <= pwdata[2:1];
            if (paddr == `CSIE_ADDR_CHG_MASKS) lmask_reg <= pwdata[3:0];
            if (paddr == `CSIE_ADDR_SOCK_MASK) smask_reg <= pwdata[3:0];
        end
    end
    AST_ERR_PHASE: assert property (pslverr |-> acc) else $error("error outside access");
    AST_ERR_DATA: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read data not zero");
    AST_MEM_NOFUNC: assert property ((card_type == 2'h0)[*4] |=> !func_irq)
        else $error("request passed for memory card");
    AST_FUNC_PASS: assert property ((card_irq_request && card_type != 2'h0
        && card_type != 2'h3)[*5] |=> func_irq)
        else $error("request not passed");
    AST_FUNC_DROP: assert property ((!card_irq_request)[*5] |=> !func_irq)
        else $error("request output stuck");
    AST_MFP_MODE: assert property ((mode_reg != 2'h0)[*2] |=> multifunction_pin == 3'h0)
        else $error("parallel pins driven in serial mode");
    AST_PIN_CODE: assert property (acc && !pwrite && paddr == `CSIE_ADDR_PIN_CODE
        |-> prdata[15:0] == ((mode_reg == 2'h2) ? 16'h0101 : 16'h0201))
        else $error("pin code wrong");
    AST_CHANGE_MASKED: assert property ((lmask_reg == 4'h0 && smask_reg == 4'h0)[*2]
        |=> !change_irq)
        else $error("masked change raised interrupt");
    // Main scenarios reached
    COV_CHANGE: cover property ($rose(change_irq));
    COV_FUNC: cover property ($rose(func_irq));
    COV_ERR: cover property (pslverr);
endmodule // csie_top_sva

bind csie_top csie_top_sva u_csie_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_type(card_type),
    .card_irq_request(card_irq_request), .change_irq(change_irq), .func_irq(func_irq),
    .multifunction_pin(multifunction_pin));

// [sim/csie_card_model.sv]
// Card side model driving socket lines
`timescale 1ns/10ps
module csie_card_model (
    // Clock
    input wire pclk,
    // Card lines
    output logic [1:0] card_type,
    output wire battery_detect_one,
    output wire battery_detect_two,
    output wire card_ready_line,
    output wire card_detect_one,
    output wire card_detect_two,
    output wire card_irq_request,
    output wire power_up_done
);
    logic [6:0] line_reg;
    // Line vector: 0,1 battery, 2 ready, 3,4 detect, 5 request, 6 power done
    assign {power_up_done, card_irq_request, card_detect_two, card_detect_one,
        card_ready_line, battery_detect_two, battery_detect_one} = line_reg;
    // Empty socket with every line low
    task automatic unplug;
        card_type <= 2'h3;
        line_reg <= 7'h00;
    endtask
    // Card swap
    task automatic insert(input logic [1:0] t);
        @(posedge pclk);
        card_type <= t;
    endtask
    // Toggle one line
    task automatic flip(input int idx);
        @(posedge pclk);
        line_reg[idx] <= ~line_reg[idx];
    endtask
    // Requests dropped unless the socket is already powered
    task automatic request(input logic v);
        @(posedge pclk);
        line_reg[5] <= v && line_reg[6];
    endtask
endmodule // csie_card_model

// [sim/card_socket_interrupt_events_bench.sv]
// Self-checking bench for the socket interrupt block
`timescale 1ns/10ps
`include "csie_defines.vh"
module card_socket_interrupt_events_bench;
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] rdata;
    logic err_seen;
    wire [31:0] prdata;
    wire pready, pslverr, change_irq, func_irq;
    wire [2:0] multifunction_pin;
    wire [1:0] card_type;
    wire bat1, bat2, rdy, det1, det2, req, pwr;
    int num_errors = 0;
    int num_checks = 0;
    always #5 pclk = ~pclk;
    csie_top u_csie_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .card_type(card_type), .battery_detect_one(bat1),
        .battery_detect_two(bat2), .card_ready_line(rdy), .card_detect_one(det1),
        .card_detect_two(det2), .card_irq_request(req), .power_up_done(pwr),
        .change_irq(change_irq), .func_irq(func_irq), .multifunction_pin(multifunction_pin));
    csie_card_model u_csie_card_model (.pclk(pclk), .card_type(card_type),
        .battery_detect_one(bat1), .battery_detect_two(bat2), .card_ready_line(rdy),
        .card_detect_one(det1), .card_detect_two(det2), .card_irq_request(req),
        .power_up_done(pwr));
    // ----
    // Helpers
    // ----
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask
    task automatic settle;
        repeat (6) @(posedge pclk);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        rd(`CSIE_ADDR_MODE_CTL, 32'h6);
        rd(`CSIE_ADDR_ROUTE, 32'h10);
        rd(`CSIE_ADDR_PIN_CODE, 32'h201);
        rd(12'h0fc, 32'h0);
        chk({31'h0, err_seen}, 32'h1);
        $display("reset test done");
    endtask
    task automatic t_mode;
        for (int m = 0; m < 4; m++) begin
            wr(`CSIE_ADDR_MODE_CTL, 32'(m << 1));
            rd(`CSIE_ADDR_PIN_CODE, (m == 2) ? 32'h101 : 32'h201);
        end
        $display("mode test done");
    endtask
    // CardBus card: socket registers only
    task automatic t_sock;
        u_csie_card_model.insert(2'h2);
        wr(`CSIE_ADDR_SOCK_MASK, 32'h6);
        u_csie_card_model.flip(3);
        settle();
        rd(`CSIE_ADDR_SOCK_EVENT, 32'h6);
        chk({31'h0, change_irq}, 32'h1);
        rd(`CSIE_ADDR_SOCK_EVENT, 32'h6);
        wr(`CSIE_ADDR_SOCK_EVENT, 32'h6);
        settle();
        chk({31'h0, change_irq}, 32'h0);
        u_csie_card_model.flip(0);
        u_csie_card_model.flip(6);
        settle();
        rd(`CSIE_ADDR_SOCK_EVENT, 32'h9);
        chk({31'h0, change_irq}, 32'h0);
        wr(`CSIE_ADDR_SOCK_EVENT, 32'h9);
        rd(`CSIE_ADDR_SOCK_EVENT, 32'h0);
        wr(`CSIE_ADDR_SOCK_MASK, 32'h0);
        $display("socket test done");
    endtask
    task automatic t_mem;
        u_csie_card_model.insert(2'h0);
        apb(1'b0, `CSIE_ADDR_CHG_FLAGS, 32'h0);
        u_csie_card_model.request(1'b1);
        u_csie_card_model.flip(0);
        u_csie_card_model.flip(1);
        u_csie_card_model.flip(2);
        u_csie_card_model.flip(6);
        u_csie_card_model.flip(6);
        settle();
        chk({31'h0, func_irq}, 32'h0);
        rd(`CSIE_ADDR_CHG_FLAGS, 32'hf);
        rd(`CSIE_ADDR_CHG_FLAGS, 32'h0);
        u_csie_card_model.request(1'b0);
        wr(`CSIE_ADDR_GLOBAL_CTL, 32'h4);
        wr(`CSIE_ADDR_CHG_MASKS, 32'h4);
        u_csie_card_model.flip(2);
        settle();
        chk({31'h0, change_irq}, 32'h1);
        rd(`CSIE_ADDR_CHG_FLAGS, 32'h4);
        rd(`CSIE_ADDR_CHG_FLAGS, 32'h4);
        wr(`CSIE_ADDR_CHG_FLAGS, 32'h4);
        settle();
        chk({31'h0, change_irq}, 32'h0);
        wr(`CSIE_ADDR_CHG_MASKS, 32'h0);
        $display("memory card test done");
    endtask
    task automatic t_io;
        u_csie_card_model.insert(2'h1);
        wr(`CSIE_ADDR_MODE_CTL, 32'h0);
        u_csie_card_model.flip(0);
        settle();
        rd(`CSIE_ADDR_CHG_FLAGS, 32'h1);
        wr(`CSIE_ADDR_CHG_FLAGS, 32'h1);
        u_csie_card_model.request(1'b1);
        settle();
        chk({31'h0, func_irq}, 32'h1);
        apb(1'b0, `CSIE_ADDR_CARD_CTL, 32'h0);
        chk(rdata & 32'h1, 32'h1);
        chk({29'h0, multifunction_pin}, 32'h2);
        wr(`CSIE_ADDR_ROUTE, 32'h20);
        settle();
        chk({29'h0, multifunction_pin}, 32'h4);
        wr(`CSIE_ADDR_MODE_CTL, 32'h6);
        settle();
        chk({29'h0, multifunction_pin}, 32'h0);
        u_csie_card_model.request(1'b0);
        settle();
        chk({31'h0, func_irq}, 32'h0);
        $display("io card test done");
    endtask
    // Main sequence
    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h00000000;
        u_csie_card_model.unplug();
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_mode();
        t_sock();
        t_mem();
        t_io();
        summarize();
    end
endmodule // card_socket_interrupt_events_bench
